/* rtl/nvm_ctrl.sv */
// Data EEPROM access controller: APB register slave, byte store and write timer.
// Assumes pclk at 25 MHz, an async power-on reset and a core-side watchdog pulse.
`timescale 1ns/100ps
`default_nettype none

module nvm_ctrl
  import nvm_ctrl_pkg::*;
#(
  parameter int ERASE_CNT = ERASE_CYCLES,
  parameter int PROG_CNT  = PROG_CYCLES
) (
  // Clock and power-on reset
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  // Secondary resets
  input  wire  logic        external_reset_pin_n,
  input  wire  logic        watchdog_timeout,
  // APB slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [31:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  // External programmer port
  input  wire  logic        code_protect,
  input  wire  logic        prog_req,
  input  wire  logic        prog_we,
  input  wire  logic [6:0]  prog_addr,
  input  wire  logic [7:0]  prog_wdata,
  output logic       [7:0]  prog_rdata,
  output logic              prog_done,
  output logic              prog_denied,
  // Interrupt
  output logic              irq
);

  // ---------------------------------------------------------------------------
  // Storage and state
  // ---------------------------------------------------------------------------
  logic [7:0]    mem [MEM_BYTES];
  logic [1:0]    pin_sync_r;
  logic          soft_rst;
  logic [7:0]    addr_r;
  logic [7:0]    data_r;
  logic          rd_r;
  logic          wr_r;
  logic          permit_r;
  logic          abort_r;
  logic [7:0]    flags_r;
  logic [7:0]    en_r;
  logic [7:0]    snap_r;
  wr_state_e     st_r;
  unlock_state_e ul_r;
  logic [CNT_W-1:0] cnt_r;
  logic [7:0]    wa_r;
  logic [7:0]    wd_r;
  logic          by_prog_r;
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;
  logic          irq_r;
  logic [7:0]    prog_rdata_r;
  logic          prog_done_r;
  logic          prog_denied_r;

  logic          setup;
  logic          acc_wr;
  logic [7:0]    idx;
  logic          wr_start;
  logic          prog_start;
  logic          wr_done;
  logic [7:0]    ctrl_view;

  function automatic logic in_range(input logic [7:0] a);
    return !a[ADDR_TOP];
  endfunction : in_range

  assign setup      = psel && !penable;
  assign acc_wr     = psel && penable && pwrite && !soft_rst;
  assign idx        = paddr[9:2];
  assign ctrl_view  = {3'h0, st_r != ST_IDLE, abort_r, permit_r, wr_r, rd_r};
  assign wr_start   = acc_wr && idx == IDX_CTRL && pwdata[CTRL_WR] && !wr_r
                      && pwdata[CTRL_PERMIT] && ul_r == UL_ARMED;
  assign prog_start = prog_req && prog_we && !code_protect && st_r == ST_IDLE
                      && !wr_start && !wr_r;
  assign wr_done    = st_r == ST_PROG && cnt_r == '0 && !soft_rst;

  // ---------------------------------------------------------------------------
  // Pin reset synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r <= 2'b11;
    end else begin
      pin_sync_r <= {pin_sync_r[0], external_reset_pin_n};
    end
  end

  assign soft_rst = !pin_sync_r[1] || watchdog_timeout;

  // ---------------------------------------------------------------------------
  // Address and data registers
  // ---------------------------------------------------------------------------
  // Kept across pin and watchdog resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= RESET_BYTE;
    end else if (acc_wr && idx == IDX_ADDR) begin
      addr_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= RESET_BYTE;
    end else if (rd_r && !soft_rst) begin
      data_r <= in_range(addr_r) ? mem[addr_r[6:0]] : RESET_BYTE;
    end else if (acc_wr && idx == IDX_DATA) begin
      data_r <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_r <= 1'b0;
    end else if (soft_rst) begin
      rd_r <= 1'b0;
    end else if (rd_r) begin
      rd_r <= 1'b0;
    end else if (acc_wr && idx == IDX_CTRL && pwdata[CTRL_RD]) begin
      rd_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_r <= 1'b0;
    end else if (soft_rst || wr_done) begin
      wr_r <= 1'b0;
    end else if (wr_start) begin
      wr_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      permit_r <= 1'b0;
    end else if (soft_rst) begin
      permit_r <= 1'b0;
    end else if (acc_wr && idx == IDX_CTRL) begin
      permit_r <= pwdata[CTRL_PERMIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_r <= 1'b0;
    end else if (soft_rst && st_r != ST_IDLE && !by_prog_r) begin
      abort_r <= 1'b1;
    end else if (acc_wr && idx == IDX_CTRL) begin
      abort_r <= pwdata[CTRL_ABORT];
    end
  end

  // ---------------------------------------------------------------------------
  // Unlock sequence tracker
  // ---------------------------------------------------------------------------
  // Any other write breaks the sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ul_r <= UL_NONE;
    end else if (soft_rst) begin
      ul_r <= UL_NONE;
    end else if (acc_wr) begin
      if (idx == IDX_UNLOCK && pwdata[7:0] == UNLOCK_KEY1) begin
        ul_r <= UL_HALF;
      end else if (idx == IDX_UNLOCK && pwdata[7:0] == UNLOCK_KEY2 && ul_r == UL_HALF) begin
        ul_r <= UL_ARMED;
      end else begin
        ul_r <= UL_NONE;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Write timer: erase then program
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= ST_IDLE;
      cnt_r     <= '0;
      wa_r      <= RESET_BYTE;
      wd_r      <= RESET_BYTE;
      by_prog_r <= 1'b0;
    end else if (soft_rst) begin
      st_r  <= ST_IDLE;
      cnt_r <= '0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (wr_start || prog_start) begin
            st_r      <= ST_ERASE;
            cnt_r     <= CNT_W'(ERASE_CNT - 1);
            wa_r      <= wr_start ? addr_r : {1'b0, prog_addr};
            wd_r      <= wr_start ? data_r : prog_wdata;
            by_prog_r <= !wr_start;
          end
        end
        ST_ERASE: begin
          if (cnt_r == '0) begin
            st_r  <= ST_PROG;
            cnt_r <= CNT_W'(PROG_CNT - 1);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_PROG: begin
          if (cnt_r == '0) begin
            st_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  // Byte store, no reset
  always_ff @(posedge pclk) begin
    if (st_r == ST_ERASE && cnt_r == '0 && !soft_rst && in_range(wa_r)) begin
      mem[wa_r[6:0]] <= ERASED_BYTE;
    end else if (wr_done && in_range(wa_r)) begin
      mem[wa_r[6:0]] <= wd_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Programmer port
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_rdata_r  <= RESET_BYTE;
      prog_done_r   <= 1'b0;
      prog_denied_r <= 1'b0;
    end else begin
      prog_denied_r <= prog_req && code_protect;
      prog_done_r   <= (prog_req && !prog_we && !code_protect) || (wr_done && by_prog_r);
      if (prog_req && !prog_we && !code_protect) begin
        prog_rdata_r <= mem[prog_addr];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt flags, read of the flag register clears what it returned
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= RESET_BYTE;
    end else begin
      flags_r <= (psel && penable && !pwrite && idx == IDX_IRQ_FLAGS) ? (flags_r & ~snap_r) : flags_r;
      if (wr_done && !by_prog_r) begin
        flags_r[FLAG_DONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= RESET_BYTE;
    end else if (acc_wr && idx == IDX_IRQ_EN) begin
      en_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flags_r & en_r);
    end
  end

  // ---------------------------------------------------------------------------
  // APB read path, captured in the setup cycle
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
      snap_r    <= RESET_BYTE;
    end else if (setup) begin
      pslverr_r <= paddr[31:10] != '0 || paddr[1:0] != 2'b00
                   || !(idx inside {IDX_IRQ_FLAGS, IDX_IRQ_EN, IDX_DATA, IDX_ADDR, IDX_CTRL, IDX_UNLOCK});
      snap_r    <= flags_r;
      unique case (idx)
        IDX_IRQ_FLAGS: prdata_r <= {24'h0, flags_r};
        IDX_IRQ_EN:    prdata_r <= {24'h0, en_r};
        IDX_DATA:      prdata_r <= {24'h0, data_r};
        IDX_ADDR:      prdata_r <= {24'h0, addr_r};
        IDX_CTRL:      prdata_r <= {24'h0, ctrl_view};
        default:       prdata_r <= '0;
      endcase
    end
  end

  // Zero wait states, low only in power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign irq         = irq_r;
  assign prog_rdata  = prog_rdata_r;
  assign prog_done   = prog_done_r;
  assign prog_denied = prog_denied_r;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence erase_end_s;
    st_r == ST_ERASE && cnt_r == '0 && !soft_rst;
  endsequence

  sequence prog_entry_s;
    st_r == ST_PROG && !in_range(wa_r) || (st_r == ST_PROG && mem[wa_r[6:0]] == ERASED_BYTE);
  endsequence

  rd_clear_a: assert property (rd_r |=> !rd_r) else $error("read start not cleared");
  rd_load_a: assert property (rd_r && !soft_rst && !addr_r[ADDR_TOP]
                              |=> data_r == mem[$past(addr_r[6:0])])
    else $error("read byte not loaded");
  wr_unlock_a: assert property ($rose(wr_r) |-> $past(ul_r) == UL_ARMED && permit_r)
    else $error("write began without unlock");
  wr_hold_a: assert property (wr_r && !wr_done && !soft_rst |=> wr_r)
    else $error("write start dropped early");
  erase_then_prog_a: assert property (erase_end_s |=> prog_entry_s)
    else $error("program phase without erase");
  done_flag_a: assert property (wr_done && !by_prog_r |=> flags_r[FLAG_DONE] && !wr_r)
    else $error("done flag not set");
  abort_set_a: assert property (soft_rst && st_r != ST_IDLE && !by_prog_r |=> abort_r && st_r == ST_IDLE)
    else $error("abort flag not set");
  keep_regs_a: assert property (soft_rst && !rd_r |=> $stable(addr_r) && $stable(data_r))
    else $error("registers lost on reset");
  unlock_zero_a: assert property (setup && idx == IDX_UNLOCK |=> prdata_r == '0)
    else $error("unlock port read nonzero");
  ctrl_upper_a: assert property (setup && idx == IDX_CTRL |=> prdata_r[7:5] == 3'h0)
    else $error("control upper bits nonzero");
  prog_deny_a: assert property (prog_req && code_protect |=> prog_denied_r && !prog_done_r)
    else $error("programmer not refused");
  wr_permit_a: assert property ($rose(st_r == ST_ERASE) && !by_prog_r |-> permit_r)
    else $error("write without permit");

endmodule : nvm_ctrl

`default_nettype wire

/* rtl/nvm_ctrl_pkg.sv */
// Constants, register map and field layout of the data EEPROM access controller.
// Assumes a 25 MHz APB clock and a core that drives APB with 32-bit words.
//
// Summary of operation
// - Storage is 128 bytes, locations 0h to 7Fh, byte read and write.
// - Each byte write erases the location first, then programs the new value.
// - Write duration comes from the internal timer, not from software timing.
// - Under code protection the core keeps access; the programmer is refused.
// - Address bits 6-0 pick one of 128 locations for the next access.
// - Address bit 7 set selects no location: reads give zero, writes are dropped; firmware keeps it zero.
// - Control register keeps only five low bits; upper three read zero.
// - Read-start and write-start can be set but not cleared by software.
// - Hardware clears read-start at read end and write-start at write end.
// - Core writes need store_permit set; store_permit is clear after power-up.
// - Pin or watchdog reset during a core write sets store_abort_flag.
// - Data and address registers keep their contents across such a reset.
// - Core write completion sets nvm_done_flag; only software clears it.
// - Unlock port has no storage and always reads zero.
// - Unlock port is used only by the write start sequence.
// - Data register holds the byte read or the byte to write.
package nvm_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Geometry and timing
  // ---------------------------------------------------------------------------
  localparam int          MEM_BYTES     = 128;
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          ERASE_TIME_US = 2000;
  localparam int          PROG_TIME_US  = 2000;
  localparam int          ERASE_CYCLES  = ERASE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int          PROG_CYCLES   = PROG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int          CNT_W         = 24;
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;

  // ---------------------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IDX_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0]  IDX_IRQ_EN    = 8'h8c;
  localparam logic [7:0]  IDX_DATA      = 8'h9a;
  localparam logic [7:0]  IDX_ADDR      = 8'h9b;
  localparam logic [7:0]  IDX_CTRL      = 8'h9c;
  localparam logic [7:0]  IDX_UNLOCK    = 8'h9d;

  // ---------------------------------------------------------------------------
  // Fields and values
  // ---------------------------------------------------------------------------
  localparam int          CTRL_RD       = 0;
  localparam int          CTRL_WR       = 1;
  localparam int          CTRL_PERMIT   = 2;
  localparam int          CTRL_ABORT    = 3;
  localparam int          CTRL_BUSY     = 4;
  localparam int          FLAG_DONE     = 7;
  localparam int          ADDR_TOP      = 7;
  localparam logic [7:0]  UNLOCK_KEY1   = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY2   = 8'haa;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ERASE = 3'b010,
    ST_PROG  = 3'b100
  } wr_state_e;

  typedef enum logic [2:0] {
    UL_NONE  = 3'b001,
    UL_HALF  = 3'b010,
    UL_ARMED = 3'b100
  } unlock_state_e;

endpackage : nvm_ctrl_pkg

/* dv/prog_port_model.sv */
// External programmer model: drives the programmer port of the controller.
// Assumes the same clock as the controller; requests are one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none

module prog_port_model (
  // Clock
  input  wire  logic       pclk,
  // Request side
  output logic             prog_req,
  output logic             prog_we,
  output logic       [6:0] prog_addr,
  output logic       [7:0] prog_wdata,
  // Answer side
  input  wire  logic [7:0] prog_rdata,
  input  wire  logic       prog_done,
  input  wire  logic       prog_denied
);
  initial begin
    prog_req   = 1'b0;
    prog_we    = 1'b0;
    prog_addr  = 7'h00;
    prog_wdata = 8'h00;
  end

  // ---------------------------------------------------------------------------
  // One access, waits for done or denial under a bound
  // ---------------------------------------------------------------------------
  task access(input logic we, input logic [6:0] a, input logic [7:0] d, output logic [7:0] rd, output logic den);
    @(posedge pclk);
    prog_req   <= 1'b1;
    prog_we    <= we;
    prog_addr  <= a;
    prog_wdata <= d;
    @(posedge pclk);
    prog_req   <= 1'b0;
    prog_addr  <= ~a;
    prog_wdata <= ~d;
    rd  = 8'h00;
    den = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge pclk);
      if (prog_done === 1'b1) begin
        rd = prog_rdata;
        break;
      end
      if (prog_denied === 1'b1) begin
        den = 1'b1;
        break;
      end
    end
  endtask : access
endmodule : prog_port_model
`default_nettype wire

/* dv/data_eeprom_access_controller_test.sv */
// Self-checking bench of the data EEPROM controller, APB master plays the core.
// Assumes short erase and program counts so each write takes ten cycles.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module data_eeprom_access_controller_test;
  import nvm_ctrl_pkg::*;
  localparam int ERS = 4;
  localparam int PRG = 6;
  logic        pclk, presetn, external_reset_pin_n, watchdog_timeout, code_protect;
  logic        psel, penable, pwrite, pready, pslverr, err_q, irq, den;
  logic        prog_req, prog_we, prog_done, prog_denied;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [6:0]  prog_addr;
  logic [7:0]  prog_wdata, prog_rdata, a, d, pr;
  logic [7:0]  mem [128];
  int          miscompares, total_checks, cyc, seed;

  nvm_ctrl #(.ERASE_CNT(ERS), .PROG_CNT(PRG)) nvm_ctrl_i (.pclk(pclk), .presetn(presetn),
    .external_reset_pin_n(external_reset_pin_n), .watchdog_timeout(watchdog_timeout), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .code_protect(code_protect), .prog_req(prog_req), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .prog_done(prog_done),
    .prog_denied(prog_denied), .irq(irq));

  prog_port_model prog_port_model_i (.pclk(pclk), .prog_req(prog_req), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .prog_done(prog_done),
    .prog_denied(prog_denied));

  // ---------------------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task end_sim;
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------------------
  // APB master and expectation helpers
  // ---------------------------------------------------------------------------
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {22'h0, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~wd;
  endtask : apb

  task wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, idx, {24'h0, v});
  endtask : wr

  task rdchk(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, idx, 32'h0);
    `CHK(rd & {24'hffffff, m}, {24'h0, e & m})
  endtask : rdchk

  function automatic logic [7:0] exp_byte(input logic [7:0] ad);
    return ad[ADDR_TOP] ? 8'h00 : mem[ad[6:0]];
  endfunction : exp_byte

  task start_wr(input logic [7:0] ad, input logic [7:0] dv);
    wr(IDX_DATA, dv);
    wr(IDX_ADDR, ad);
    wr(IDX_CTRL, 8'h04);
    wr(IDX_UNLOCK, UNLOCK_KEY1);
    rdchk(IDX_UNLOCK, 8'hff, 8'h00);
    wr(IDX_UNLOCK, UNLOCK_KEY2);
    wr(IDX_CTRL, 8'h06);
    if (!ad[ADDR_TOP]) mem[ad[6:0]] = dv;
  endtask : start_wr

  task wait_wr;
    for (int i = 0; i < 50; i++) begin
      apb(1'b0, IDX_CTRL, 32'h0);
      if (rd[CTRL_WR] === 1'b0) break;
    end
    `CHK(rd[CTRL_WR], 1'b0)
  endtask : wait_wr

  task core_rd(input logic [7:0] ad);
    wr(IDX_ADDR, ad);
    wr(IDX_CTRL, 8'h01);
    rdchk(IDX_DATA, 8'hff, exp_byte(ad));
    rdchk(IDX_CTRL, 8'h01, 8'h00);
  endtask : core_rd

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 37;
    presetn = 1'b0;
    external_reset_pin_n = 1'b1;
    watchdog_timeout = 1'b0;
    code_protect = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(IDX_IRQ_FLAGS, 8'hff, 8'h00);
    rdchk(IDX_CTRL, 8'hff, 8'h00);
    apb(1'b0, 8'h00, 32'h0);
    `CHK({err_q, rd}, 33'h1_0000_0000)
    wr(IDX_CTRL, 8'he4);
    rdchk(IDX_CTRL, 8'hff, 8'h04);
    // Corner addresses and data first, then random ones
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 8'h00 : (i < 3) ? 8'h7f : (i == 3) ? 8'h80 : {1'b0, 7'($random(seed))};
      d = (i == 1) ? 8'h00 : (i == 2) ? 8'hff : 8'($random(seed));
      wr(IDX_IRQ_EN, {i[0], 7'h0});
      rdchk(IDX_IRQ_EN, 8'hff, {i[0], 7'h0});
      start_wr(a, d);
      wr(IDX_CTRL, 8'h04);
      rdchk(IDX_CTRL, 8'h02, 8'h02);
      rdchk(IDX_CTRL, 8'h02, 8'h02);
      wait_wr();
      `CHK(irq, i[0])
      rdchk(IDX_IRQ_FLAGS, 8'hff, 8'h80);
      rdchk(IDX_IRQ_FLAGS, 8'hff, 8'h00);
      `CHK(irq, 1'b0)
      core_rd(a);
    end
    // Broken unlock sequence, then permit clear
    wr(IDX_UNLOCK, UNLOCK_KEY1);
    wr(IDX_UNLOCK, UNLOCK_KEY2);
    wr(IDX_DATA, 8'h5a);
    wr(IDX_CTRL, 8'h06);
    rdchk(IDX_CTRL, 8'h02, 8'h00);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_UNLOCK, UNLOCK_KEY1);
    wr(IDX_UNLOCK, UNLOCK_KEY2);
    wr(IDX_CTRL, 8'h02);
    rdchk(IDX_CTRL, 8'h02, 8'h00);
    // Programmer refused under protection, core keeps access
    code_protect <= 1'b1;
    prog_port_model_i.access(1'b0, a[6:0], 8'h00, pr, den);
    `CHK(den, 1'b1)
    core_rd(a);
    code_protect <= 1'b0;
    prog_port_model_i.access(1'b1, 7'h05, 8'h3c, pr, den);
    mem[5] = 8'h3c;
    core_rd(8'h05);
    prog_port_model_i.access(1'b0, 7'h05, 8'h00, pr, den);
    `CHK(pr, 8'h3c)
    // Write cut short by watchdog, then by the external pin
    for (int k = 0; k < 2; k++) begin
      a = {1'b0, 7'($random(seed))};
      d = 8'($random(seed));
      start_wr(a, d);
      if (k == 0) watchdog_timeout <= 1'b1;
      else external_reset_pin_n <= 1'b0;
      repeat (3) @(posedge pclk);
      watchdog_timeout <= 1'b0;
      external_reset_pin_n <= 1'b1;
      repeat (4) @(posedge pclk);
      rdchk(IDX_CTRL, 8'h0f, 8'h08);
      rdchk(IDX_DATA, 8'hff, d);
      rdchk(IDX_ADDR, 8'hff, a);
      wr(IDX_CTRL, 8'h00);
    end
    end_sim();
  end
endmodule : data_eeprom_access_controller_test
`default_nettype wire
